// file: dv/reset_line_model.sv
`default_nettype none
module reset_line_model (
    input  wire logic level_in,
    input  wire logic oe_in,
    output logic      pin_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // shared pin with pull-up: released pin reads high
    assign pin_out = oe_in ? level_in : 1'b1;
endmodule // reset_line_model
`default_nettype wire

// file: dv/watchdog_timer_tb.sv
`default_nettype none
module watchdog_timer_tb;
    import watchdog_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk_in;
    logic       srst_in;
    reg_req_t   req_in;
    logic [7:0] rdata_out;
    logic       internal_reset_out;
    logic       reset_pin_out;
    logic       reset_pin_oe_out;
    logic       pin_level;
    int         errors;
    int         n_tests;
    int         i;
    logic [7:0] d;

    watchdog_timer u_dut (.clk_in(clk_in), .srst_in(srst_in),
        .req_in(req_in), .rdata_out(rdata_out),
        .internal_reset_out(internal_reset_out),
        .reset_pin_out(reset_pin_out),
        .reset_pin_oe_out(reset_pin_oe_out));
    reset_line_model u_line (.level_in(reset_pin_out),
        .oe_in(reset_pin_oe_out), .pin_out(pin_level));

    initial begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end

    function automatic logic [7:0] master_val(input logic e, input logic [1:0] p,
                                              input logic dr);
        return {e, p, dr, compat_value};
    endfunction

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_in);
        req_in <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge clk_in);
        req_in <= '0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_in);
        req_in <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk_in);
        req_in <= '0;
        #1 chk(rdata_out, exp);
    endtask

    task automatic do_reset();
        srst_in <= 1'b1;
        repeat (10) @(posedge clk_in);
        srst_in <= 1'b0;
    endtask

    task automatic results();
        $display("errors=%0d n_tests=%0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    initial begin
        #3_000_000;
        errors++;
        results();
    end

    initial begin
        errors = 0;
        n_tests = 0;
        srst_in = 1'b1;
        req_in = '0;
        void'($urandom(75));
        do_reset();
        rd(master_offset, master_val(1'b1, period_reset, 1'b1));
        wr(master_offset, master_val(1'b1, 2'h0, 1'b1));
        wr(command_offset, disable_code);
        for (i = 0; i < 6; i++) begin
            d = 8'($urandom);
            if (d == clear_code || d == disable_code) d = d ^ 8'h01;
            wr(command_offset, d);
        end
        rd(master_offset, master_val(1'b1, 2'h0, 1'b1));
        repeat (2000) @(posedge clk_in);
        wr(command_offset, clear_code);
        for (i = 0; i < 70000 && internal_reset_out !== 1'b1; i++)
            @(posedge clk_in);
        chk(8'(i > 65530 && i < 65540), 8'h01);
        #1 chk({7'h00, pin_level}, 8'h00);
        do_reset();
        chk({6'h00, internal_reset_out, pin_level}, 8'h01);
        rd(master_offset, master_val(1'b1, period_reset, 1'b1));
        wr(master_offset, master_val(1'b0, 2'h0, 1'b1));
        rd(master_offset, master_val(1'b1, 2'h0, 1'b1));
        wr(command_offset, disable_code);
        rd(master_offset, master_val(1'b0, 2'h0, 1'b1));
        rd(command_offset, 8'h00);
        for (i = 0; i < 4; i++) begin
            d = 8'($urandom) & 8'h7F;
            rd(d, 8'h00);
        end
        results();
    end
endmodule // watchdog_timer_tb
`default_nettype wire

// file: include/watchdog_pkg.sv
`default_nettype none
package watchdog_pkg;
    localparam logic [7:0] command_offset     = 8'hF1;
    localparam logic [7:0] master_offset      = 8'hF0;
    localparam logic [7:0] clear_code         = 8'h4E;
    localparam logic [7:0] disable_code       = 8'hB1;
    localparam logic [1:0] period_reset       = 2'h3;
    localparam logic [3:0] compat_value       = 4'h3;
    localparam int         enable_pos         = 7;
    localparam int         period_hi          = 6;
    localparam int         period_lo          = 5;
    localparam int         drive_pos          = 4;
    localparam int         count_width        = 22;
    localparam int         pulse_width_cycles = 16;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } reg_req_t;
endpackage
`default_nettype wire

// file: logic/watchdog_timer.sv
// Overview of operation
// - after every reset the watchdog is enabled and its enable bit reads 1.
// - disabling takes a write of enable 0 then the disable code, in order.
// - the disable code acts only while the written enable bit is 0; bit 7 still reads 1 until the disable code lands.
// - the clear code resets the count to zero and restarts the interval.
// - period field 0,1,2,3 gives 2^16, 2^18, 2^20, 2^22 clock periods.
// - the period field resets to 3, the longest interval.
// - a timeout while enabled resets the whole device.
// - with drive bit 1 a timeout also pulls the reset pin low.
// - compatibility bits are written as 0011 and always read as 0011.
//
// The strobed register port is this design's own decision.
`default_nettype none
module watchdog_timer
    import watchdog_pkg::*;
#(
    parameter int pulse_cycles = pulse_width_cycles
) (
    input  wire logic       clk_in,
    input  wire logic       srst_in,
    input  wire reg_req_t   req_in,
    output logic      [7:0] rdata_out,
    output logic            internal_reset_out,
    output logic            reset_pin_out,
    output logic            reset_pin_oe_out
);
    initial begin
        if (pulse_cycles < 1 || pulse_cycles > 255) begin
            $error("pulse_cycles out of range");
        end
    end

    logic                   enable_bit;
    logic                   running;
    logic [1:0]             period_select_field;
    logic                   drive_external_reset_bit;
    logic [count_width-1:0] count;
    logic                   timeout;
    logic [7:0]             pulse_count;
    logic                   pulse_ext;

    wire wr_master  = req_in.wr && req_in.addr == master_offset;
    wire wr_command = req_in.wr && req_in.addr == command_offset;
    wire cmd_clear  = wr_command && req_in.wdata == clear_code;
    wire cmd_disable = wr_command && req_in.wdata == disable_code;

    always_comb begin
        case (period_select_field)
            2'h0:    timeout = running && (&count[15:0]);
            2'h1:    timeout = running && (&count[17:0]);
            2'h2:    timeout = running && (&count[19:0]);
            2'h3:    timeout = running && (&count[21:0]);
            default: timeout = 1'b0;
        endcase
    end

    // master register fields
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            enable_bit               <= 1'b1;
            period_select_field      <= period_reset;
            drive_external_reset_bit <= 1'b1;
        end else if (wr_master) begin
            enable_bit               <= req_in.wdata[enable_pos];
            period_select_field      <= req_in.wdata[period_hi:period_lo];
            drive_external_reset_bit <= req_in.wdata[drive_pos];
        end
    end

    // running state: stops only via the two-step sequence
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            running <= 1'b1;
        end else if (wr_master && req_in.wdata[enable_pos]) begin
            running <= 1'b1;
        end else if (cmd_disable && !enable_bit) begin
            running <= 1'b0;
        end
    end

    // counter; unknown commands fall through untouched
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            count <= '0;
        end else if (cmd_clear || !running || timeout) begin
            count <= '0;
        end else begin
            count <= count + 1'b1;
        end
    end

    // timeout reset pulse
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            pulse_count <= 8'h00;
            pulse_ext   <= 1'b0;
        end else if (timeout) begin
            pulse_count <= 8'(pulse_cycles);
            pulse_ext   <= drive_external_reset_bit;
        end else if (pulse_count != 8'h00) begin
            pulse_count <= pulse_count - 8'h01;
        end else begin
            pulse_ext <= 1'b0;
        end
    end

    always_comb begin
        internal_reset_out = pulse_count != 8'h00;
        reset_pin_oe_out   = internal_reset_out && pulse_ext;
        reset_pin_out      = 1'b0;
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            rdata_out <= 8'h00;
        end else if (req_in.rd && req_in.addr == master_offset) begin
            rdata_out <= {running, period_select_field,
                          drive_external_reset_bit, compat_value};
        end else begin
            rdata_out <= 8'h00;
        end
    end

    property p_disable_needs_zero;
        @(posedge clk_in) disable iff (srst_in)
        (cmd_disable && enable_bit && running && !wr_master) |=> running;
    endproperty
    a_disable_needs_zero: assert property (p_disable_needs_zero)
        else $error("disable accepted while enabled");

    property p_disable_works;
        @(posedge clk_in) disable iff (srst_in)
        (cmd_disable && !enable_bit && !wr_master) |=> !running;
    endproperty
    a_disable_works: assert property (p_disable_works)
        else $error("two-step disable failed");

    property p_clear;
        @(posedge clk_in) disable iff (srst_in)
        cmd_clear |=> count == '0;
    endproperty
    a_clear: assert property (p_clear)
        else $error("clear did not zero count");

    property p_compat;
        @(posedge clk_in) disable iff (srst_in)
        (req_in.rd && req_in.addr == master_offset) |=> rdata_out[3:0] == 4'h3;
    endproperty
    a_compat: assert property (p_compat)
        else $error("compat bits wrong");

    property p_timeout_reset;
        @(posedge clk_in) disable iff (srst_in)
        timeout |=> internal_reset_out;
    endproperty
    a_timeout_reset: assert property (p_timeout_reset)
        else $error("timeout without reset");

    property p_pin;
        @(posedge clk_in) disable iff (srst_in)
        timeout |=> reset_pin_oe_out == $past(drive_external_reset_bit);
    endproperty
    a_pin: assert property (p_pin)
        else $error("pin drive mismatch");

    property p_reset_state;
        @(posedge clk_in)
        srst_in |=> running && period_select_field == 2'h3;
    endproperty
    a_reset_state: assert property (p_reset_state)
        else $error("reset state wrong");

    property p_ignore;
        @(posedge clk_in) disable iff (srst_in)
        (wr_command && !cmd_clear && !cmd_disable && running && !timeout)
            |=> running && count == $past(count) + 1'b1;
    endproperty
    a_ignore: assert property (p_ignore)
        else $error("unknown command had effect");

    property p_stopped;
        @(posedge clk_in) disable iff (srst_in)
        !running |=> !internal_reset_out || $past(internal_reset_out);
    endproperty
    a_stopped: assert property (p_stopped)
        else $error("timeout while disabled");
endmodule // watchdog_timer
`default_nettype wire
